// [core/flash_pkg.sv]
package flash_pkg;

   localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
   localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
   localparam logic [7:0] STATUS_LO_CMD = 8'h05;
   localparam logic [7:0] STATUS_HI_CMD = 8'h35;
   localparam logic [7:0] QUAD_IO_READ_CMD = 8'hEB;
   localparam logic [7:0] WRAP_SET_CMD = 8'h77;
   localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
   localparam logic [7:0] QUAD_PROGRAM_CMD = 8'h32;
   localparam logic [7:0] SECTOR_ERASE_CMD = 8'h20;
   localparam logic [7:0] BLOCK_ERASE_CMD = 8'h52;

   // Field lengths in bits; quad read dummy clocks
   localparam logic [5:0] CMD_BITS = 6'h08;
   localparam logic [5:0] ADDR_BITS = 6'h18;
   localparam logic [5:0] MODE_BITS = 6'h08;
   localparam logic [5:0] DATA_BITS = 6'h08;
   localparam logic [5:0] WRAP_FRAME_BITS = 6'h20;
   localparam logic [5:0] DUMMY_CLKS = 6'h04;

   // Mode byte nibble that keeps continuous read
   localparam logic [3:0] CONT_KEEP_NIBBLE = 4'hA;

   // Wrap bits, msb first; bit 0 disables wrapping (default)
   localparam int WRAP_DISABLE_POS = 0;
   localparam logic [2:0] WRAP_RESET = 3'h1;
   localparam logic [7:0] WRAP_MIN_BYTES = 8'h08;

   // Status layout: low byte bit 0/1, high byte bit 1 (status bit 9)
   localparam int BUSY_POS = 0;
   localparam int LATCH_POS = 1;
   localparam int QUAD_EN_POS = 1;

   // Array geometry and protection granularity
   localparam int DEV_ADDR_W = 21;
   localparam int PROT_BASE_SHIFT = 15;
   localparam int PAGE_BYTES = 256;
   localparam int FIFO_DEPTH = 8;

   // Self-timed cycle lengths
   localparam longint CLK_HZ = 20_000_000;
   localparam longint PROG_TIME_NS = 400_000;
   localparam longint SECTOR_TIME_NS = 45_000_000;
   localparam longint BLOCK_TIME_NS = 150_000_000;
   localparam int PROG_CYCLES = int'((PROG_TIME_NS * CLK_HZ) / 64'd1_000_000_000);
   localparam int SECTOR_CYCLES = int'((SECTOR_TIME_NS * CLK_HZ) / 64'd1_000_000_000);
   localparam int BLOCK_CYCLES = int'((BLOCK_TIME_NS * CLK_HZ) / 64'd1_000_000_000);

   typedef enum logic [3:0] {
      ST_CMD    = 4'h0,
      ST_ADDR   = 4'h1,
      ST_MODE   = 4'h2,
      ST_DUMMY  = 4'h3,
      ST_RDATA  = 4'h4,
      ST_PDATA  = 4'h5,
      ST_EDONE  = 4'h6,
      ST_STAT   = 4'h7,
      ST_WRAP   = 4'h8,
      ST_IGNORE = 4'h9
   } phase_e;

endpackage

// [core/flash_wr_fifo.sv]
`timescale 1ns/10ps
module flash_wr_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW:0] wr_ptr_ff;
   logic [AW:0] rd_ptr_ff;
   logic full;
   logic empty;
   logic push;
   logic pop;

   // Extra pointer bit tells full from empty
   assign empty = (wr_ptr_ff == rd_ptr_ff);
   assign full = (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]) && (wr_ptr_ff[AW] != rd_ptr_ff[AW]);
   assign in_ready_o = ~full;
   assign out_valid_o = ~empty;
   assign push = in_valid_i & ~full & ce_i;
   assign pop = out_ready_i & ~empty & ce_i;
   assign out_data_o = mem_ff[rd_ptr_ff[AW-1:0]];

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
         if (pop)
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (push)
         mem_ff[wr_ptr_ff[AW-1:0]] <= in_data_i;
   end

endmodule

// [core/flash_cmd_seq.sv]
// Contract
// R1 - Mode byte A?h: next quad read after reselect skips the command.
// R2 - Other mode byte leaves continuous mode; next frame needs a command.
// R3 - Host may send a mode reset frame to leave continuous mode.
// R4 - With wrap on, quad read wraps within aligned 8/16/32/64 byte section.
// R5 - Wrap setup frame: 77h, 24 dummy bits, one wrap byte, then deselect.
// R6 - Wrap bit 4 low enables wrap; bits 6:5 pick length; default disabled.
// R7 - Stored wrap setting applies to all later quad reads until rewritten.
// R8 - Program and erase accepted only with write enable latch set.
// R9 - Single-line program: 02h, three address bytes, at least one data byte.
// R10 - Program data past page end continues at the start of that page.
// R11 - Over 256 data bytes: only the last 256 programmed.
// R12 - Fewer bytes: only addressed bytes programmed, rest of page kept.
// R13 - Program runs only if deselect follows a whole data byte.
// R14 - Deselect starts self-timed program; busy bit high till end; latch cleared.
// R15 - Status reads are answered while a program or erase cycle runs.
// R16 - Program to a protected page is not executed.
// R17 - Quad program 32h on four lines needs the quad enable bit set.
// R18 - Sector erase 20h plus address runs only if deselect follows address.
// R19 - Valid sector erase runs self-timed with busy bit high, clears latch.
// R20 - Sector erase to a protected sector is not executed.
// R21 - Block erase 52h plus address; deselect right after last address bit.
// R22 - Protected block erase not executed; accepted one runs self-timed busy.
// R23 - Commands decoded from each select start; early deselect abandons frame.
`timescale 1ns/10ps
module flash_cmd_seq #(
   parameter int PROG_CYC = flash_pkg::PROG_CYCLES,
   parameter int SECTOR_CYC = flash_pkg::SECTOR_CYCLES,
   parameter int BLOCK_CYC = flash_pkg::BLOCK_CYCLES,
   parameter int FIFO_DEPTH = flash_pkg::FIFO_DEPTH
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   // Serial link pins
   input wire logic chip_select_n_i,
   input wire logic serial_clock_i,
   input wire logic [3:0] data_line_i,
   output logic [3:0] data_line_o,
   output logic [3:0] data_line_oe_o,
   // Configuration and status
   input wire logic quad_enable_bit_i,
   input wire logic [4:0] block_protect_bits_i,
   output logic write_in_progress_o,
   output logic write_enable_latch_o,
   output logic [2:0] wrap_bits_o,
   output logic continuous_read_o,
   // Array read port
   output logic [23:0] mem_raddr_o,
   input wire logic [7:0] mem_rdata_i,
   // Array program stream
   output logic prog_valid_o,
   input wire logic prog_ready_i,
   output logic [23:0] prog_addr_o,
   output logic [7:0] prog_data_o,
   // Array erase request
   output logic erase_req_o,
   output logic [23:0] erase_addr_o,
   output logic erase_block_o
);
   localparam int PB = flash_pkg::PAGE_BYTES;

   function automatic logic prot_hit(input logic [23:0] a, input logic [4:0] bp);
      logic [21:0] lim;
      logic [21:0] off;
      lim = 22'h000001 << (flash_pkg::PROT_BASE_SHIFT + int'(bp[2:0]));
      off = bp[3] ? {1'b0, a[20:0]} : (22'h1FFFFF - {1'b0, a[20:0]});
      return (bp[2:0] != 3'h0) && (off < lim);
   endfunction

   // First stage feeds only the second
   logic [5:0] sync1_ff;
   logic [5:0] sync2_ff;
   logic sclk_d_ff;
   logic cs_d_ff;
   logic cs_n;
   logic sclk;
   logic [3:0] dq;
   logic rise;
   logic fall;
   logic cs_rise;

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         sync1_ff <= 6'h01;
         sync2_ff <= 6'h01;
         sclk_d_ff <= 1'b0;
         cs_d_ff <= 1'b1;
      end
      else if (ce_i)
      begin
         sync1_ff <= {data_line_i, serial_clock_i, chip_select_n_i};
         sync2_ff <= sync1_ff;
         sclk_d_ff <= sclk;
         cs_d_ff <= cs_n;
      end
   end

   assign cs_n = sync2_ff[0];
   assign sclk = sync2_ff[1];
   assign dq = sync2_ff[5:2];
   assign rise = ce_i & ~cs_n & sclk & ~sclk_d_ff;
   assign fall = ce_i & ~cs_n & ~sclk & sclk_d_ff;
   assign cs_rise = ce_i & cs_n & ~cs_d_ff;

   flash_pkg::phase_e st_ff;
   logic [7:0] cmd_ff;
   logic [31:0] sh_ff;
   logic [5:0] cnt_ff;
   logic quad_ff;
   logic [23:0] addr_ff;
   logic [7:0] pidx_ff;
   logic [PB-1:0] pvalid_ff;
   logic [7:0] pbuf_ff [PB];
   logic got_byte_ff;
   logic [23:0] rd_addr_ff;
   logic nib_ff;
   logic [2:0] sr_bit_ff;
   logic [3:0] dq_o_ff;
   logic [3:0] dq_oe_ff;
   logic wel_ff;
   logic cont_ff;
   logic [2:0] wrap_ff;
   logic wip_ff;
   logic [31:0] busy_cnt_ff;
   logic [7:0] walk_ff;
   logic walking_ff;
   logic erase_req_ff;
   logic erase_block_ff;

   logic [31:0] nxt_sh;
   logic [5:0] nxt_cnt;
   logic byte_done;
   logic [7:0] status_byte;
   logic wrap_en;
   logic [7:0] wrap_mask;
   logic [23:0] rd_inc;
   logic [23:0] nxt_rd_addr;
   logic prot;
   logic start_prog;
   logic start_erase;
   logic [7:0] rx_byte;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [31:0] fifo_out_data;
   logic cycle_done;

   assign nxt_sh = quad_ff ? {sh_ff[27:0], dq} : {sh_ff[30:0], dq[0]};
   assign nxt_cnt = cnt_ff + (quad_ff ? 6'h04 : 6'h01);
   assign rx_byte = nxt_sh[7:0];
   assign byte_done = (nxt_cnt == flash_pkg::DATA_BITS);
   assign status_byte = (cmd_ff == flash_pkg::STATUS_HI_CMD)
                      ? (8'h00 | (8'(quad_enable_bit_i) << flash_pkg::QUAD_EN_POS))
                      : ((8'(wel_ff) << flash_pkg::LATCH_POS) | (8'(wip_ff) << flash_pkg::BUSY_POS));
   assign wrap_en = ~wrap_ff[flash_pkg::WRAP_DISABLE_POS]; // R6
   assign wrap_mask = (flash_pkg::WRAP_MIN_BYTES << wrap_ff[2:1]) - 8'h01; // R6
   assign rd_inc = rd_addr_ff + 24'h000001;
   assign nxt_rd_addr = wrap_en
      ? {rd_addr_ff[23:8], (rd_addr_ff[7:0] & ~wrap_mask) | (rd_inc[7:0] & wrap_mask)}
      : rd_inc; // R4
   assign prot = prot_hit(addr_ff, block_protect_bits_i); // R16 R20 R22
   assign start_prog = cs_rise & (st_ff == flash_pkg::ST_PDATA) & (cnt_ff == 6'h00)
                     & got_byte_ff & ~prot; // R13 R16
   assign start_erase = cs_rise & (st_ff == flash_pkg::ST_EDONE) & ~prot; // R18 R20 R21 R22

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         st_ff <= flash_pkg::ST_CMD;
         cmd_ff <= 8'h00;
         sh_ff <= 32'h00000000;
         cnt_ff <= 6'h00;
         quad_ff <= 1'b0;
         addr_ff <= 24'h000000;
         pidx_ff <= 8'h00;
         pvalid_ff <= '0;
         got_byte_ff <= 1'b0;
         rd_addr_ff <= 24'h000000;
         nib_ff <= 1'b0;
         sr_bit_ff <= 3'h7;
         dq_o_ff <= 4'h0;
         dq_oe_ff <= 4'h0;
         wel_ff <= 1'b0;
         cont_ff <= 1'b0;
         wrap_ff <= flash_pkg::WRAP_RESET;
         erase_req_ff <= 1'b0;
         erase_block_ff <= 1'b0;
      end
      else if (ce_i)
      begin
         erase_req_ff <= start_erase;
         if (start_erase)
            erase_block_ff <= (cmd_ff == flash_pkg::BLOCK_ERASE_CMD);
         if (start_prog | start_erase)
            wel_ff <= 1'b0; // R14 R19
         if (cs_n)
         begin
            // Deselect abandons any partial frame
            st_ff <= (cont_ff & ~wip_ff) ? flash_pkg::ST_ADDR : flash_pkg::ST_CMD; // R1 R23
            cmd_ff <= (cont_ff & ~wip_ff) ? flash_pkg::QUAD_IO_READ_CMD : cmd_ff;
            quad_ff <= cont_ff & ~wip_ff;
            cnt_ff <= 6'h00;
            dq_oe_ff <= 4'h0;
         end
         else if (fall)
         begin
            case (st_ff)
               flash_pkg::ST_RDATA:
               begin
                  dq_oe_ff <= 4'hF;
                  dq_o_ff <= nib_ff ? mem_rdata_i[3:0] : mem_rdata_i[7:4];
                  nib_ff <= ~nib_ff;
                  if (nib_ff)
                     rd_addr_ff <= nxt_rd_addr; // R4 R7
               end
               flash_pkg::ST_STAT:
               begin
                  dq_oe_ff <= 4'h2;
                  dq_o_ff <= {2'h0, status_byte[sr_bit_ff], 1'b0}; // R15
                  sr_bit_ff <= sr_bit_ff - 3'h1;
               end
               default:
               begin
                  dq_oe_ff <= 4'h0;
               end
            endcase
         end
         else if (rise)
         begin
            sh_ff <= nxt_sh;
            cnt_ff <= nxt_cnt;
            case (st_ff)
               flash_pkg::ST_CMD:
               begin
                  if (nxt_cnt == flash_pkg::CMD_BITS) // R23
                  begin
                     cmd_ff <= rx_byte;
                     cnt_ff <= 6'h00;
                     st_ff <= flash_pkg::ST_IGNORE;
                     sr_bit_ff <= 3'h7;
                     if (rx_byte == flash_pkg::STATUS_LO_CMD || rx_byte == flash_pkg::STATUS_HI_CMD)
                        st_ff <= flash_pkg::ST_STAT; // R15
                     else if (!wip_ff)
                     begin
                        case (rx_byte)
                           flash_pkg::WRITE_ENABLE_CMD: wel_ff <= 1'b1;
                           flash_pkg::WRITE_DISABLE_CMD: wel_ff <= 1'b0;
                           flash_pkg::WRAP_SET_CMD: st_ff <= flash_pkg::ST_WRAP; // R5
                           flash_pkg::QUAD_IO_READ_CMD:
                           begin
                              st_ff <= quad_enable_bit_i ? flash_pkg::ST_ADDR
                                                         : flash_pkg::ST_IGNORE;
                              quad_ff <= quad_enable_bit_i;
                           end
                           flash_pkg::PAGE_PROGRAM_CMD, flash_pkg::SECTOR_ERASE_CMD,
                           flash_pkg::BLOCK_ERASE_CMD:
                              st_ff <= wel_ff ? flash_pkg::ST_ADDR : flash_pkg::ST_IGNORE; // R8
                           flash_pkg::QUAD_PROGRAM_CMD:
                           begin
                              st_ff <= (wel_ff & quad_enable_bit_i) ? flash_pkg::ST_ADDR
                                                                   : flash_pkg::ST_IGNORE; // R8 R17
                              quad_ff <= wel_ff & quad_enable_bit_i;
                           end
                           default: st_ff <= flash_pkg::ST_IGNORE;
                        endcase
                     end
                  end
               end
               flash_pkg::ST_ADDR:
               begin
                  if (nxt_cnt == flash_pkg::ADDR_BITS)
                  begin
                     addr_ff <= nxt_sh[23:0];
                     rd_addr_ff <= nxt_sh[23:0];
                     pidx_ff <= nxt_sh[7:0];
                     cnt_ff <= 6'h00;
                     pvalid_ff <= '0;
                     got_byte_ff <= 1'b0;
                     case (cmd_ff)
                        flash_pkg::QUAD_IO_READ_CMD: st_ff <= flash_pkg::ST_MODE;
                        flash_pkg::PAGE_PROGRAM_CMD, flash_pkg::QUAD_PROGRAM_CMD:
                           st_ff <= flash_pkg::ST_PDATA; // R9 R17
                        default: st_ff <= flash_pkg::ST_EDONE; // R18 R21
                     endcase
                  end
               end
               flash_pkg::ST_MODE:
               begin
                  if (nxt_cnt == flash_pkg::MODE_BITS)
                  begin
                     cont_ff <= (rx_byte[7:4] == flash_pkg::CONT_KEEP_NIBBLE); // R1 R2
                     cnt_ff <= 6'h00;
                     st_ff <= flash_pkg::ST_DUMMY;
                  end
               end
               flash_pkg::ST_DUMMY:
               begin
                  cnt_ff <= cnt_ff + 6'h01;
                  nib_ff <= 1'b0;
                  if (cnt_ff == flash_pkg::DUMMY_CLKS - 6'h01)
                     st_ff <= flash_pkg::ST_RDATA;
               end
               flash_pkg::ST_PDATA:
               begin
                  if (byte_done)
                  begin
                     cnt_ff <= 6'h00;
                     got_byte_ff <= 1'b1;
                     pvalid_ff[pidx_ff] <= 1'b1; // R11 R12
                     pidx_ff <= pidx_ff + 8'h01; // R10
                  end
               end
               flash_pkg::ST_WRAP:
               begin
                  if (nxt_cnt == flash_pkg::WRAP_FRAME_BITS)
                  begin
                     wrap_ff <= rx_byte[6:4]; // R5 R6 R7
                     st_ff <= flash_pkg::ST_IGNORE;
                  end
               end
               // Extra clock voids erase
               flash_pkg::ST_EDONE: st_ff <= flash_pkg::ST_IGNORE; // R18 R21
               default: cnt_ff <= 6'h00;
            endcase
         end
      end
   end

   // Repeat offset overwrites: last 256 bytes win
   always_ff @(posedge clk_i)
   begin
      if (rise && st_ff == flash_pkg::ST_PDATA && byte_done)
         pbuf_ff[pidx_ff] <= rx_byte; // R11
   end

   // Walk page buffer into FIFO while the timer runs out
   assign fifo_in_valid = walking_ff & pvalid_ff[walk_ff]; // R12
   assign cycle_done = wip_ff & ~walking_ff & ~fifo_out_valid & (busy_cnt_ff == 32'h0);

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         wip_ff <= 1'b0;
         busy_cnt_ff <= 32'h0;
         walk_ff <= 8'h00;
         walking_ff <= 1'b0;
      end
      else if (ce_i)
      begin
         if (start_prog | start_erase)
         begin
            wip_ff <= 1'b1; // R14 R19 R22
            walking_ff <= start_prog;
            walk_ff <= 8'h00;
            busy_cnt_ff <= start_prog ? 32'(PROG_CYC)
                         : (cmd_ff == flash_pkg::BLOCK_ERASE_CMD) ? 32'(BLOCK_CYC)
                         : 32'(SECTOR_CYC);
         end
         else
         begin
            if (busy_cnt_ff != 32'h0)
               busy_cnt_ff <= busy_cnt_ff - 32'h1;
            if (walking_ff && (!pvalid_ff[walk_ff] || fifo_in_ready))
            begin
               walk_ff <= walk_ff + 8'h01;
               if (walk_ff == 8'hFF)
                  walking_ff <= 1'b0;
            end
            if (cycle_done)
               wip_ff <= 1'b0; // R14
         end
      end
   end

   flash_wr_fifo #(
      .WIDTH(32),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .ce_i(ce_i),
      .in_valid_i(fifo_in_valid),
      .in_ready_o(fifo_in_ready),
      .in_data_i({addr_ff[23:8], walk_ff, pbuf_ff[walk_ff]}),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(prog_ready_i),
      .out_data_o(fifo_out_data)
   );

   assign data_line_o = dq_o_ff;
   assign data_line_oe_o = dq_oe_ff & {4{~cs_n}};
   assign write_in_progress_o = wip_ff;
   assign write_enable_latch_o = wel_ff;
   assign wrap_bits_o = wrap_ff;
   assign continuous_read_o = cont_ff;
   assign mem_raddr_o = rd_addr_ff;
   assign prog_valid_o = fifo_out_valid;
   assign prog_addr_o = fifo_out_data[31:8];
   assign prog_data_o = fifo_out_data[7:0];
   assign erase_req_o = erase_req_ff;
   assign erase_addr_o = addr_ff;
   assign erase_block_o = erase_block_ff;

endmodule

// [tb/flash_cmd_seq_sva.sv]
`timescale 1ns/10ps
module flash_cmd_seq_sva (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Watched ports
   input wire logic chip_select_n_i,
   input wire logic [3:0] data_line_oe_o,
   input wire logic write_in_progress_o,
   input wire logic write_enable_latch_o,
   input wire logic [2:0] wrap_bits_o,
   input wire logic continuous_read_o,
   input wire logic prog_valid_o,
   input wire logic prog_ready_i,
   input wire logic [23:0] prog_addr_o,
   input wire logic erase_req_o,
   input wire logic erase_block_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   logic [23:0] last_addr_ff;
   logic seen_ff;
   wire accept = prog_valid_o && prog_ready_i;
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         last_addr_ff <= 24'h000000;
         seen_ff <= 1'b0;
      end
      else if (accept)
      begin
         last_addr_ff <= prog_addr_o;
         seen_ff <= 1'b1;
      end
      else if (!write_in_progress_o)
         seen_ff <= 1'b0;
   end
   a_busy_needs_latch: assert property ($rose(write_in_progress_o) |->
      $past(write_enable_latch_o) || $past(write_enable_latch_o, 2))
      else $error("no latch");
   a_latch_drops_busy: assert property ($rose(write_in_progress_o) |->
      ##[0:4] !write_enable_latch_o) else $error("latch not cleared");
   a_erase_one_pulse: assert property (erase_req_o |=> !erase_req_o)
      else $error("long erase");
   a_erase_goes_busy: assert property (erase_req_o |->
      ##[0:2] write_in_progress_o) else $error("erase without busy");
   a_prog_in_cycle: assert property (prog_valid_o |-> write_in_progress_o)
      else $error("prog idle");
   a_prog_page_order: assert property (accept && seen_ff |->
      prog_addr_o[23:8] == last_addr_ff[23:8] && prog_addr_o[7:0] > last_addr_ff[7:0])
      else $error("prog order");
   a_wrap_in_frame: assert property (!$stable(wrap_bits_o) |->
      !$past(chip_select_n_i, 2)) else $error("wrap idle");
   a_mode_in_frame: assert property ($rose(continuous_read_o) |->
      !$past(chip_select_n_i, 2)) else $error("mode idle");
   a_drive_in_frame: assert property (|data_line_oe_o |->
      !$past(chip_select_n_i, 2) || !$past(chip_select_n_i, 3))
      else $error("drive idle");
   c_block_erase: cover property (erase_req_o && erase_block_o);
   c_prog_byte: cover property (accept);
   c_cont_mode: cover property ($rose(continuous_read_o));
endmodule

// [tb/spi_host_model.sv]
`timescale 1ns/10ps
module spi_host_model (
   // Link pins
   output logic cs_n_o,
   output logic sclk_o,
   output logic [3:0] host_data_o,
   // Resolved wire
   input wire logic [3:0] wire_data_i
);
   localparam time HALF = 200ns;
   logic [3:0] last;
   initial
   begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      host_data_o = 4'h0;
      last = 4'h0;
   end
   task automatic select_low();
      cs_n_o = 1'b0;
   endtask
   task automatic deselect();
      #(HALF);
      cs_n_o = 1'b1;
      host_data_o = ~last;
      #(HALF * 2);
   endtask
   task automatic clock_out(input logic [3:0] v);
      host_data_o = v;
      last = v;
      #(HALF);
      sclk_o = 1'b1;
      #(HALF);
      sclk_o = 1'b0;
   endtask
   task automatic send_byte(input logic [7:0] b, input logic quad);
      if (quad)
      begin
         clock_out(b[7:4]);
         clock_out(b[3:0]);
      end
      else
         for (int i = 7; i >= 0; i--)
            clock_out({~last[3:1], b[i]});
   endtask
   task automatic recv_byte(input logic quad, output logic [7:0] b);
      host_data_o = ~last;
      for (int i = 0; i < (quad ? 2 : 8); i++)
      begin
         #(HALF);
         sclk_o = 1'b1;
         #(HALF);
         b = quad ? {b[3:0], wire_data_i} : {b[6:0], wire_data_i[1]};
         sclk_o = 1'b0;
      end
   endtask
endmodule

// [tb/serial_flash_program_erase_wrap_tb_top.sv]
`timescale 1ns/10ps
module serial_flash_program_erase_wrap_tb_top;
   localparam logic [7:0] LATCH_ON = flash_pkg::WRITE_ENABLE_CMD;
   localparam logic [7:0] SEC = flash_pkg::SECTOR_ERASE_CMD;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic qe = 1'b1, ce = 1'b1;
   logic [4:0] bp = 5'h00;
   logic prog_ready_i = 1'b0;
   logic cs_n, sclk, write_in_progress, write_enable_latch, cont, pvalid, ereq, eblk;
   logic [3:0] host_data, dout, doe, wire_data;
   logic [2:0] wrap;
   logic [7:0] pdata;
   logic [23:0] raddr, paddr, eaddr;
   logic [31:0] prog_q[$];
   logic [24:0] erase_q[$];
   int miscompares = 0;
   int samples_checked = 0;
   assign wire_data = (doe & dout) | (~doe & host_data);
   flash_cmd_seq #(.PROG_CYC(300), .SECTOR_CYC(400), .BLOCK_CYC(500)) i_flash_cmd_seq (
      .clk_i, .resetn_i, .ce_i(ce), .chip_select_n_i(cs_n), .serial_clock_i(sclk),
      .data_line_i(wire_data), .data_line_o(dout), .data_line_oe_o(doe),
      .quad_enable_bit_i(qe), .block_protect_bits_i(bp), .write_in_progress_o(write_in_progress),
      .write_enable_latch_o(write_enable_latch), .wrap_bits_o(wrap), .continuous_read_o(cont),
      .mem_raddr_o(raddr), .mem_rdata_i(raddr[7:0] ^ 8'h5A), .prog_valid_o(pvalid),
      .prog_ready_i, .prog_addr_o(paddr), .prog_data_o(pdata), .erase_req_o(ereq),
      .erase_addr_o(eaddr), .erase_block_o(eblk));
   spi_host_model i_spi_host_model (.cs_n_o(cs_n), .sclk_o(sclk), .host_data_o(host_data),
      .wire_data_i(wire_data));
   initial
   begin
      forever #25 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
   begin
      prog_ready_i <= #2 ~prog_ready_i;
      if (pvalid && prog_ready_i)
         prog_q.push_back({paddr, pdata});
      if (ereq)
         erase_q.push_back({eblk, eaddr});
   end
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic frame(input logic [7:0] q[$], input int extra);
      i_spi_host_model.select_low();
      foreach (q[i])
         i_spi_host_model.send_byte(q[i], 1'b0);
      repeat (extra)
         i_spi_host_model.clock_out(4'h1);
      i_spi_host_model.deselect();
   endtask
   task automatic status(input logic [7:0] exp);
      logic [7:0] s;
      i_spi_host_model.select_low();
      i_spi_host_model.send_byte(flash_pkg::STATUS_LO_CMD, 1'b0);
      i_spi_host_model.recv_byte(1'b0, s);
      i_spi_host_model.deselect();
      check("status", exp, s);
   endtask
   task automatic wait_idle();
      ce = 1'b0;
      repeat (50)
         @(posedge clk_i);
      #2 ce = 1'b1;
      repeat (6000)
         @(posedge clk_i);
      status(8'h00);
   endtask
   task automatic quad_read(input logic cmd, input logic [31:0] am, input logic [7:0] exp[$]);
      logic [7:0] b;
      i_spi_host_model.select_low();
      if (cmd)
         i_spi_host_model.send_byte(flash_pkg::QUAD_IO_READ_CMD, 1'b0);
      for (int i = 3; i >= 0; i--)
         i_spi_host_model.send_byte(am[i*8 +: 8], 1'b1);
      repeat (flash_pkg::DUMMY_CLKS)
         i_spi_host_model.clock_out(4'hF);
      foreach (exp[i])
      begin
         i_spi_host_model.recv_byte(1'b1, b);
         check("quad byte", exp[i], b);
      end
      i_spi_host_model.deselect();
   endtask
   task automatic end_of_test();
      $display("compared %0d, mismatched %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      #4ms;
      miscompares++;
      end_of_test();
   end
   initial
   begin
      logic [31:0] exp_prog[3] = '{32'h001200A3, 32'h0012FEA1, 32'h0012FFA2};
      repeat (10)
         @(posedge clk_i);
      #2 resetn_i = 1'b1;
      repeat (4)
         @(posedge clk_i);
      check("reset", 32'h2, {write_in_progress, write_enable_latch, wrap, cont});
      frame({8'h02, 8'h00, 8'h10, 8'h00, 8'h11}, 0);
      status(8'h00);
      frame({LATCH_ON}, 0);
      frame({8'h02, 8'h00, 8'h10, 8'h00, 8'h11}, 4);
      status(8'h02);
      frame({8'h02, 8'h00, 8'h12, 8'hFE, 8'hA1, 8'hA2, 8'hA3}, 0);
      status(8'h01);
      wait_idle();
      check("prog count", 32'h3, prog_q.size());
      foreach (exp_prog[i])
         check("prog byte", exp_prog[i], prog_q[i]);
      frame({LATCH_ON}, 0);
      frame({SEC, 8'h00, 8'h34, 8'h56}, 0);
      status(8'h01);
      wait_idle();
      frame({LATCH_ON}, 0);
      frame({flash_pkg::BLOCK_ERASE_CMD, 8'h01, 8'h00, 8'h00}, 0);
      wait_idle();
      frame({LATCH_ON}, 0);
      frame({SEC, 8'h00, 8'h34, 8'h56}, 1);
      @(posedge clk_i);
      #2 bp = 5'h01;
      frame({SEC, 8'h1F, 8'h80, 8'h00}, 0);
      frame({flash_pkg::BLOCK_ERASE_CMD, 8'h1F, 8'h00, 8'h00}, 0);
      status(8'h02);
      check("erase count", 32'h2, erase_q.size());
      check("sector erase", 32'h0003456, erase_q[0]);
      check("block erase", 32'h1010000, erase_q[1]);
      for (int c = 3; c >= 0; c--)
      begin
         logic [7:0] w;
         w = {1'b0, c[1:0], 5'h00};
         frame({flash_pkg::WRAP_SET_CMD, 8'h00, 8'h00, 8'h00, w}, 0);
         check("wrap bits", {c[1:0], 1'b0}, wrap);
      end
      quad_read(1'b1, 32'h000406A5, {8'h5C, 8'h5D, 8'h5A});
      check("continuous on", 32'h1, cont);
      quad_read(1'b0, 32'h00041000, {8'h4A});
      check("continuous off", 32'h0, cont);
      frame({flash_pkg::WRAP_SET_CMD, 8'h00, 8'h00, 8'h00, 8'h10}, 0);
      check("wrap off", 32'h1, wrap);
      quad_read(1'b1, 32'h000407FF, {8'h5D, 8'h52});
      end_of_test();
   end
endmodule
bind flash_cmd_seq flash_cmd_seq_sva i_flash_cmd_seq_sva (.clk_i, .resetn_i, .chip_select_n_i,
   .data_line_oe_o, .write_in_progress_o, .write_enable_latch_o, .wrap_bits_o,
   .continuous_read_o, .prog_valid_o, .prog_ready_i, .prog_addr_o, .erase_req_o,
   .erase_block_o);
